/* File: rtl/irq_router_map.svh */
/*
 * offsets-free constant map for the dual core interrupt router:
 * source counts, line counts, priority widths, selector reset values.
 * assumes inclusion by bare name from the router package and module.
 */
`ifndef IRQ_ROUTER_MAP_SVH
`define IRQ_ROUTER_MAP_SVH

`define NUM_SOURCES 147
`define SRC_SEL_W 8
`define NUM_SEC_LINES 32
`define MAIN_PRIO_W 3
`define SEC_PRIO_W 2
`define NUM_WAKE_SOURCES 41
`define SEL_NONE 8'hFF

`endif

/* File: rtl/irq_router_pkg.sv */
/*
 * types shared by the interrupt router: source vectors, selectors,
 * per-core configuration carriers.
 * assumes the constant map header is on the include path.
 */
`include "irq_router_map.svh"

package irq_router_pkg;
    typedef logic [`NUM_SOURCES-1:0] src_vec_type;
    typedef logic [`SRC_SEL_W-1:0] src_sel_type;

    // one selector per secondary line plus one nmi selector per core
    typedef struct packed {
        src_sel_type [`NUM_SEC_LINES-1:0] line_sel;
        src_sel_type main_nmi_sel;
        src_sel_type sec_nmi_sel;
    } route_cfg_type;

    // system function requesters
    typedef struct packed {
        logic main_core;
        logic secondary_core;
        logic debug_access_port;
    } sysfn_req_type;

    typedef enum logic [1:0] {
        CFG_LINE,
        CFG_MAIN_NMI,
        CFG_SEC_NMI
    } cfg_target_type;
endpackage

/* File: rtl/dual_cpu_interrupt_router.sv */
/*
 * dual core interrupt router: direct main-core lines, selectable
 * secondary-core lines, per-core nmi selection, per-source priority,
 * deep-sleep wakeup gating, system-function nmi to the secondary core.
 * assumes all inputs are synchronous to clk_in; configuration is
 * written through a plain write strobe port, there is no bus.
 */
// Function
// - 147 sources drive main-core lines directly
// - 32 secondary lines, each selects one source
// - per-source priority: eight main, four secondary
// - one selectable nmi source per core
// - at most 41 sources wake from deep-sleep
// - system-function request raises secondary-core nmi
`timescale 1ns/1ps
`include "irq_router_map.svh"

module dual_cpu_interrupt_router (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // interrupt sources
    input wire irq_router_pkg::src_vec_type src_irq_in,
    // configuration write port
    input wire logic cfg_we_in,
    input wire irq_router_pkg::cfg_target_type cfg_target_in,
    input wire logic [4:0] cfg_line_in,
    input wire irq_router_pkg::src_sel_type cfg_sel_in,
    input wire logic prio_we_in,
    input wire irq_router_pkg::src_sel_type prio_src_in,
    input wire logic [`MAIN_PRIO_W-1:0] prio_main_in,
    input wire logic [`SEC_PRIO_W-1:0] prio_sec_in,
    // power and system functions
    input wire logic deep_sleep_in,
    input wire irq_router_pkg::src_vec_type wake_en_in,
    input wire irq_router_pkg::sysfn_req_type sysfn_req_in,
    input wire logic sysfn_done_in,
    // main core
    output irq_router_pkg::src_vec_type main_irq_out,
    output logic [`NUM_SOURCES*`MAIN_PRIO_W-1:0] main_prio_out,
    output logic main_nmi_out,
    // secondary core
    output logic [`NUM_SEC_LINES-1:0] sec_irq_out,
    output logic [`NUM_SEC_LINES*`SEC_PRIO_W-1:0] sec_prio_out,
    output logic sec_nmi_out,
    output logic sysfn_pending_out,
    // wakeup
    output logic wake_out
);

    irq_router_pkg::route_cfg_type cfg;
    logic [`MAIN_PRIO_W-1:0] main_prio [`NUM_SOURCES];
    logic [`SEC_PRIO_W-1:0] sec_prio [`NUM_SOURCES];
    irq_router_pkg::src_vec_type src_q;
    logic sysfn_pending;
    logic [`NUM_SEC_LINES-1:0] sec_irq;
    logic [`NUM_SEC_LINES*`SEC_PRIO_W-1:0] sec_prio_flat;
    logic main_nmi, sec_nmi_src, wake;

    // sources registered once; main lines come straight from flip-flops, secondary lines and priorities pass through select logic
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            src_q <= '0;
        end else begin
            src_q <= src_irq_in;
        end
    end

    // direct mapping, no remap on the main core
    assign main_irq_out = src_q;

    // configuration writes; selectors default to no source
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < `NUM_SEC_LINES; i++) begin
                cfg.line_sel[i] <= `SEL_NONE;
            end
            cfg.main_nmi_sel <= `SEL_NONE;
            cfg.sec_nmi_sel <= `SEL_NONE;
        end else if (cfg_we_in) begin
            unique case (cfg_target_in)
                irq_router_pkg::CFG_LINE:
                    cfg.line_sel[cfg_line_in] <= cfg_sel_in;
                irq_router_pkg::CFG_MAIN_NMI:
                    cfg.main_nmi_sel <= cfg_sel_in;
                irq_router_pkg::CFG_SEC_NMI:
                    cfg.sec_nmi_sel <= cfg_sel_in;
                default: ;
            endcase
        end
    end

    // priority tables; out-of-range source writes are dropped
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < `NUM_SOURCES; i++) begin
                main_prio[i] <= '0;
                sec_prio[i] <= '0;
            end
        end else if (prio_we_in && prio_src_in < `SRC_SEL_W'(`NUM_SOURCES)) begin
            main_prio[prio_src_in] <= prio_main_in;
            sec_prio[prio_src_in] <= prio_sec_in;
        end
    end

    // per-line selection; codes at or above the source count pick none
    for (genvar l = 0; l < `NUM_SEC_LINES; l++) begin : g_line
        wire logic [`SRC_SEL_W-1:0] sel = cfg.line_sel[l];
        wire logic hit = sel < `SRC_SEL_W'(`NUM_SOURCES);
        assign sec_irq[l] = hit && src_q[sel];
        assign sec_prio_flat[l*`SEC_PRIO_W +: `SEC_PRIO_W] =
            hit ? sec_prio[sel] : '0;
    end
    for (genvar s = 0; s < `NUM_SOURCES; s++) begin : g_prio
        assign main_prio_out[s*`MAIN_PRIO_W +: `MAIN_PRIO_W] = main_prio[s];
    end
    assign sec_irq_out = sec_irq;
    assign sec_prio_out = sec_prio_flat;

    // nmi selection, one source per core
    assign main_nmi = cfg.main_nmi_sel < `SRC_SEL_W'(`NUM_SOURCES) &&
        src_q[cfg.main_nmi_sel];
    assign sec_nmi_src = cfg.sec_nmi_sel < `SRC_SEL_W'(`NUM_SOURCES) &&
        src_q[cfg.sec_nmi_sel];

    // only the low 41 sources are wake capable; wider enables ignored
    localparam irq_router_pkg::src_vec_type WAKE_CAPABLE =
        {{(`NUM_SOURCES-`NUM_WAKE_SOURCES){1'b0}},
         {`NUM_WAKE_SOURCES{1'b1}}};
    assign wake = deep_sleep_in &&
        |(src_irq_in & wake_en_in & WAKE_CAPABLE);

    // sticky system-function request; a new request beats the done
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sysfn_pending <= 1'b0;
        end else begin
            sysfn_pending <= (|sysfn_req_in) ||
                (sysfn_pending && !sysfn_done_in);
        end
    end

    // outputs held in flip-flops
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            main_nmi_out <= 1'b0;
            sec_nmi_out <= 1'b0;
            wake_out <= 1'b0;
        end else begin
            main_nmi_out <= main_nmi;
            sec_nmi_out <= sec_nmi_src || sysfn_pending;
            wake_out <= wake;
        end
    end
    assign sysfn_pending_out = sysfn_pending;

    // checks
    property p_main_direct;
        @(posedge clk_in) disable iff (!rst_n_in)
        main_irq_out == $past(src_irq_in);
    endproperty
    a_main_direct: assert property (p_main_direct)
        else $error("main line differs from source");

    // written through the port, so a broken write path shows up here
    property p_line_none;
        @(posedge clk_in) disable iff (!rst_n_in)
        (cfg_we_in && cfg_target_in == irq_router_pkg::CFG_LINE &&
            cfg_sel_in >= `SRC_SEL_W'(`NUM_SOURCES)) |=>
            !sec_irq_out[$past(cfg_line_in)];
    endproperty
    a_line_none: assert property (p_line_none)
        else $error("unselected line active");

    property p_line_follow;
        @(posedge clk_in) disable iff (!rst_n_in)
        (cfg_we_in && cfg_target_in == irq_router_pkg::CFG_LINE &&
            cfg_sel_in < `SRC_SEL_W'(`NUM_SOURCES)) |=>
            sec_irq_out[$past(cfg_line_in)] == $past(src_irq_in[cfg_sel_in]);
    endproperty
    a_line_follow: assert property (p_line_follow)
        else $error("line does not follow its source");

    property p_prio_write;
        @(posedge clk_in) disable iff (!rst_n_in)
        (prio_we_in && prio_src_in == 8'h00) |=>
            main_prio_out[2:0] == $past(prio_main_in);
    endproperty
    a_prio_write: assert property (p_prio_write)
        else $error("priority not stored");

    property p_nmi_sel;
        @(posedge clk_in) disable iff (!rst_n_in)
        (cfg_we_in && cfg_target_in == irq_router_pkg::CFG_MAIN_NMI) |=>
            cfg.main_nmi_sel == $past(cfg_sel_in);
    endproperty
    a_nmi_sel: assert property (p_nmi_sel)
        else $error("nmi selector not taken");

    property p_wake_gate;
        @(posedge clk_in) disable iff (!rst_n_in)
        !deep_sleep_in |=> !wake_out;
    endproperty
    a_wake_gate: assert property (p_wake_gate)
        else $error("wake outside deep-sleep");

    property p_sysfn_nmi;
        @(posedge clk_in) disable iff (!rst_n_in)
        (|sysfn_req_in) |=> ##1 sec_nmi_out;
    endproperty
    a_sysfn_nmi: assert property (p_sysfn_nmi)
        else $error("system function gave no nmi");

    property p_sysfn_hold;
        @(posedge clk_in) disable iff (!rst_n_in)
        (sysfn_pending && !sysfn_done_in) |=> sysfn_pending;
    endproperty
    a_sysfn_hold: assert property (p_sysfn_hold)
        else $error("system function request lost");

    // a request in the cycle of the done must still set the flag
    property p_sysfn_set;
        @(posedge clk_in) disable iff (!rst_n_in)
        (|sysfn_req_in) |=> sysfn_pending;
    endproperty
    a_sysfn_set: assert property (p_sysfn_set)
        else $error("new request lost to done");

    property p_reset_none;
        @(posedge clk_in)
        $rose(rst_n_in) |-> cfg.sec_nmi_sel == `SEL_NONE;
    endproperty
    a_reset_none: assert property (p_reset_none)
        else $error("selector not cleared by reset");

    c_line: cover property (@(posedge clk_in) sec_irq_out[0]);
    c_nmi: cover property (@(posedge clk_in) main_nmi_out);
    c_wake: cover property (@(posedge clk_in) wake_out);
    c_sysfn: cover property (@(posedge clk_in) sysfn_pending_out);

endmodule // dual_cpu_interrupt_router

/* File: verif/sec_core_model.sv */
/*
 * secondary core stand-in: answers a system-function nmi with done.
 * assumes it shares clk_in with the router; slow_in stretches the answer.
 */
`timescale 1ns/1ps
module sec_core_model (
    // clock and pace
    input wire logic clk_in,
    input wire logic slow_in,
    // router side
    input wire logic sec_nmi_in,
    input wire logic sysfn_pending_in,
    output logic sysfn_done_out
);
    logic [3:0] wait_cnt;
    // run the function, then pulse done until pending drops
    always_ff @(posedge clk_in) begin
        sysfn_done_out <= 1'b0;
        if (!(sec_nmi_in && sysfn_pending_in)) begin
            wait_cnt <= slow_in ? 4'hA : 4'h2;
        end else if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
        end else begin
            sysfn_done_out <= 1'b1;
        end
    end
endmodule // sec_core_model

/* File: verif/dual_cpu_interrupt_router_test.sv */
/*
 * self-checking bench for the dual core interrupt router.
 * assumes the router package and map header are compiled first.
 */
`timescale 1ns/1ps
module dual_cpu_interrupt_router_test;
    logic clk_in, rst_n_in, cfg_we, prio_we, deep_sleep, slow, done;
    logic main_nmi, sec_nmi, pending, wake;
    irq_router_pkg::src_vec_type src, wake_en, main_irq;
    irq_router_pkg::cfg_target_type cfg_target;
    irq_router_pkg::src_sel_type cfg_sel, prio_src;
    irq_router_pkg::sysfn_req_type sysfn_req;
    logic [4:0] cfg_line;
    logic [2:0] prio_main;
    logic [1:0] prio_sec;
    logic [440:0] main_prio, exp_prio;
    logic [31:0] sec_irq;
    logic [63:0] sec_prio;
    int n_mismatch = 0;
    int num_checks = 0;

    dual_cpu_interrupt_router DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .src_irq_in(src), .cfg_we_in(cfg_we), .cfg_target_in(cfg_target),
        .cfg_line_in(cfg_line), .cfg_sel_in(cfg_sel), .prio_we_in(prio_we),
        .prio_src_in(prio_src), .prio_main_in(prio_main),
        .prio_sec_in(prio_sec), .deep_sleep_in(deep_sleep),
        .wake_en_in(wake_en), .sysfn_req_in(sysfn_req),
        .sysfn_done_in(done), .main_irq_out(main_irq),
        .main_prio_out(main_prio), .main_nmi_out(main_nmi),
        .sec_irq_out(sec_irq), .sec_prio_out(sec_prio),
        .sec_nmi_out(sec_nmi), .sysfn_pending_out(pending),
        .wake_out(wake));
    sec_core_model core (.clk_in(clk_in), .slow_in(slow),
        .sec_nmi_in(sec_nmi), .sysfn_pending_in(pending),
        .sysfn_done_out(done));

    // 50 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    task automatic check(input logic [447:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // strobes dropped a cycle apart so no edge sees a double write
    task automatic cfg(input irq_router_pkg::cfg_target_type t,
                       input logic [4:0] l, input logic [7:0] s);
        cfg_we = 1'b1; cfg_target = t; cfg_line = l; cfg_sel = s;
        tick(1); cfg_we = 1'b0; tick(1);
    endtask
    task automatic prio(input logic [7:0] s, input logic [2:0] m,
                        input logic [1:0] q);
        prio_we = 1'b1; prio_src = s; prio_main = m; prio_sec = q;
        tick(1); prio_we = 1'b0; tick(1);
    endtask

    // selectors come up empty: all sources high lights only main lines
    task automatic t_reset;
        src = '1; tick(2);
        check(main_irq, {147{1'b1}});
        check({sec_irq, sec_nmi, main_nmi}, 34'h0);
        src = '0; tick(1);
    endtask
    task automatic t_direct;
        foreach (src[i]) begin
            src = '0; src[i] = 1'b1; tick(1);
            check(main_irq, src);
        end
        src = '0;
    endtask
    // top and bottom sources on edge lines, one line left unselected
    task automatic t_lines;
        cfg(irq_router_pkg::CFG_LINE, 5'd31, 8'd146);
        cfg(irq_router_pkg::CFG_LINE, 5'd0, 8'd0);
        cfg(irq_router_pkg::CFG_LINE, 5'd5, 8'hFF);
        src = '1; tick(1);
        check(sec_irq, 32'h80000001);
        src[146] = 1'b0; tick(1);
        check(sec_irq, 32'h00000001);
        src = '0;
    endtask
    // a write to source 147 must change nothing
    task automatic t_prio;
        prio(8'd146, 3'h7, 2'h3);
        prio(8'd0, 3'h5, 2'h2);
        prio(8'd147, 3'h1, 2'h1);
        exp_prio = '0; exp_prio[440:438] = 3'h7; exp_prio[2:0] = 3'h5;
        check(main_prio, exp_prio);
        check({sec_prio[63:62], sec_prio[1:0]}, 4'hE);
    endtask
    task automatic t_nmi;
        cfg(irq_router_pkg::CFG_MAIN_NMI, 5'd0, 8'd10);
        cfg(irq_router_pkg::CFG_SEC_NMI, 5'd0, 8'd20);
        src[10] = 1'b1; tick(2);
        check({main_nmi, sec_nmi}, 2'b10);
        src[10] = 1'b0; src[20] = 1'b1; tick(2);
        check({main_nmi, sec_nmi}, 2'b01);
        src = '0; tick(2);
    endtask
    // source 41 lies past the wake-capable range even when enabled
    task automatic t_wake;
        wake_en = '0; wake_en[41:40] = 2'b11; deep_sleep = 1'b1;
        src[41] = 1'b1; tick(2);
        check(wake, 1'b0);
        src[40] = 1'b1; tick(2);
        check(wake, 1'b1);
        deep_sleep = 1'b0; tick(2);
        check(wake, 1'b0);
        src = '0;
    endtask
    // every requester, core answering fast and slow
    task automatic t_sysfn;
        for (int k = 0; k < 3; k++) begin
            slow = k[0];
            sysfn_req = irq_router_pkg::sysfn_req_type'(3'b001 << k);
            tick(1); sysfn_req = '0;
            check(pending, 1'b1);
            tick(1);
            check(sec_nmi, 1'b1);
            for (int w = 0; w < 30 && pending !== 1'b0; w++) tick(1);
            tick(2);
            check({pending, sec_nmi}, 2'b00);
        end
        // request held through the done: the set wins
        slow = 1'b0;
        sysfn_req = '1;
        for (int w = 0; w < 30 && done !== 1'b1; w++) tick(1);
        tick(1);
        check(pending, 1'b1);
        sysfn_req = '0;
        for (int w = 0; w < 30 && pending !== 1'b0; w++) tick(1);
        tick(2);
        check({pending, sec_nmi}, 2'b00);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // watchdog well past the few hundred cycles the tests need
    initial begin
        #200us;
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        rst_n_in = 1'b0; cfg_we = 1'b0; prio_we = 1'b0; deep_sleep = 1'b0;
        slow = 1'b0; src = '0; wake_en = '0; sysfn_req = '0;
        cfg_target = irq_router_pkg::CFG_LINE; cfg_line = 5'h0;
        cfg_sel = 8'hFF; prio_src = 8'h0; prio_main = 3'h0; prio_sec = 2'h0;
        repeat (16) @(posedge clk_in);
        @(negedge clk_in) rst_n_in = 1'b1;
        t_reset(); t_direct(); t_lines(); t_prio();
        t_nmi(); t_wake(); t_sysfn();
        report_and_stop();
    end
endmodule // dual_cpu_interrupt_router_test
